/* File: src/etr_readout.sv */
/*
 * ECC self-test result readout: holds the upper result bytes of the
 * encoder/decoder self-test and the last corrected-error block
 * address, readable over APB, with event status, mask and interrupt.
 * Assumes the self-test engine and the memory corrector run on
 * clock_i and give one-cycle strobes; the APB master follows the
 * usual setup/access protocol.
 */
// Decided for this implementation: the APB slave port.
`include "etr_cfg.svh"

`default_nettype none

module etr_readout #(
   parameter int ADDR_W = `ETR_ADDR_W,
   parameter int DATA_W = `ETR_DATA_W
) (
   input  wire logic              clock_i,
   input  wire logic              resetn_i,
   // apb slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [DATA_W-1:0] pwdata_i,
   output logic      [DATA_W-1:0] prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // self-test engine
   input  wire logic              test_result_valid_i,
   input  wire logic              encode_decode_select_i,
   input  wire logic [23:0]       test_result_upper_i,
   // memory corrector
   input  wire logic              sec_event_i,
   input  wire logic [7:0]        sec_block_i,
   input  wire logic              single_error_detected_flag_i,
   // interrupt
   output logic                   irq_o
);

   // ************************************************************
   // address map
   // ************************************************************
   localparam logic [ADDR_W-1:0] A_BYTE6 =
      ADDR_W'({`ETR_IDX_BYTE6, 2'b00});
   localparam logic [ADDR_W-1:0] A_BYTE7 =
      ADDR_W'({`ETR_IDX_BYTE7, 2'b00});
   localparam logic [ADDR_W-1:0] A_BYTE8 =
      ADDR_W'({`ETR_IDX_BYTE8, 2'b00});
   localparam logic [ADDR_W-1:0] A_CORRECTED_ERROR_BLOCK_ADDR =
      ADDR_W'({`ETR_IDX_CORRECTED_ERROR_BLOCK_ADDR, 2'b00});
   localparam logic [ADDR_W-1:0] A_EVT_STAT =
      ADDR_W'({`ETR_IDX_EVT_STAT, 2'b00});
   localparam logic [ADDR_W-1:0] A_EVT_MASK =
      ADDR_W'({`ETR_IDX_EVT_MASK, 2'b00});
   localparam logic [ADDR_W-1:0] A_INFO =
      ADDR_W'({`ETR_IDX_INFO, 2'b00});

   localparam int BW = `ETR_BYTE_W;
   localparam int NE = `ETR_NUM_EVT;

   // ************************************************************
   // declarations
   // ************************************************************
   etr_pkg::etr_apb_state_t apb_state_q;
   etr_pkg::etr_apb_state_t apb_state_d;

   logic [BW-1:0]     byte6_q;
   logic [BW-1:0]     byte7_q;
   logic [BW-1:0]     byte8_q;
   logic [BW-1:0]     corrected_error_block_addr_q;
   logic [NE-1:0]     evt_status;
   logic [NE-1:0]     evt_mask_q;
   logic [NE-1:0]     evt_set;
   logic [NE-1:0]     evt_clr;
   logic              mode_q;
   logic              held_q;
   logic              sec_flag_q;

   wire               setup_phase;
   wire               access_phase;
   wire               wr_commit;
   wire               dec_done;
   wire               enc_done;
   wire               byte8_clear;
   wire               sec_overwrite;
   wire               hit_byte6;
   wire               hit_byte7;
   wire               hit_byte8;
   wire               hit_corrected_error_block_addr;
   wire               hit_evt_stat;
   wire               hit_evt_mask;
   wire               hit_info;
   wire               hit_any;
   wire [DATA_W-1:0]  rd_mux;
   wire [DATA_W-1:0]  info_word;

   // ************************************************************
   // self-test result capture
   // ************************************************************
   // direction of the finished test decides which bytes are live
   assign dec_done = test_result_valid_i &
                     (encode_decode_select_i ==
                      etr_pkg::ETR_MODE_DECODE);
   assign enc_done = test_result_valid_i &
                     (encode_decode_select_i ==
                      etr_pkg::ETR_MODE_ENCODE);

   // decoder results end at byte seven, so byte eight is cleared
   // to avoid a stale encoder byte being mistaken for part of it
   assign byte8_clear = dec_done;

   // bytes six and seven belong to both directions
   etr_byte_hold #(
      .W (BW)
   ) u_byte6 (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .load_i   (test_result_valid_i),
      .clear_i  (1'b0),
      .data_i   (test_result_upper_i[7:0]),
      .q_o      (byte6_q)
   );

   etr_byte_hold #(
      .W (BW)
   ) u_byte7 (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .load_i   (test_result_valid_i),
      .clear_i  (1'b0),
      .data_i   (test_result_upper_i[15:8]),
      .q_o      (byte7_q)
   );

   // ninth byte carries data only for the encoder test
   etr_byte_hold #(
      .W (BW)
   ) u_byte8 (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .load_i   (enc_done),
      .clear_i  (byte8_clear),
      .data_i   (test_result_upper_i[23:16]),
      .q_o      (byte8_q)
   );

   // ************************************************************
   // corrected-error block address
   // ************************************************************
   // newest correction always replaces the older address
   etr_byte_hold #(
      .W (BW)
   ) u_corrected_error_block_addr (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .load_i   (sec_event_i),
      .clear_i  (1'b0),
      .data_i   (sec_block_i),
      .q_o      (corrected_error_block_addr_q)
   );

   // a second correction while the flag is still up loses history
   assign sec_overwrite = sec_event_i & sec_flag_q;

   // mode of last result, result-held marker, detect flag copy
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_q     <= 1'b0;
         held_q     <= 1'b0;
         sec_flag_q <= 1'b0;
      end else begin
         if (test_result_valid_i) begin
            mode_q <= encode_decode_select_i;
            held_q <= 1'b1;
         end
         sec_flag_q <= single_error_detected_flag_i;
      end
   end

   // ************************************************************
   // event status, mask and interrupt
   // ************************************************************
   assign evt_set = {sec_overwrite, sec_event_i, enc_done, dec_done};
   assign evt_clr = (wr_commit & hit_evt_stat) ?
                    pwdata_i[NE-1:0] : {NE{1'b0}};

   etr_sticky_bank #(
      .N (NE)
   ) u_events (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .set_i    (evt_set),
      .clr_i    (evt_clr),
      .mask_i   (evt_mask_q),
      .status_o (evt_status),
      .irq_o    (irq_o)
   );

   // mask is the only register software can load
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         evt_mask_q <= `ETR_MASK_RST;
      end else if (wr_commit && hit_evt_mask) begin
         evt_mask_q <= pwdata_i[NE-1:0];
      end
   end

   // ************************************************************
   // apb address decode
   // ************************************************************
   assign hit_byte6    = (paddr_i == A_BYTE6);
   assign hit_byte7    = (paddr_i == A_BYTE7);
   assign hit_byte8    = (paddr_i == A_BYTE8);
   assign hit_corrected_error_block_addr  = (paddr_i == A_CORRECTED_ERROR_BLOCK_ADDR);
   assign hit_evt_stat = (paddr_i == A_EVT_STAT);
   assign hit_evt_mask = (paddr_i == A_EVT_MASK);
   assign hit_info     = (paddr_i == A_INFO);
   assign hit_any      = hit_byte6 | hit_byte7 | hit_byte8 |
                         hit_corrected_error_block_addr | hit_evt_stat | hit_evt_mask |
                         hit_info;

   assign info_word = DATA_W'({held_q, sec_flag_q, mode_q});

   // narrow registers sit in the low bits, upper bits read zero
   assign rd_mux =
      hit_byte6    ? DATA_W'(byte6_q)    :
      hit_byte7    ? DATA_W'(byte7_q)    :
      hit_byte8    ? DATA_W'(byte8_q)    :
      hit_corrected_error_block_addr  ? DATA_W'(corrected_error_block_addr_q)  :
      hit_evt_stat ? DATA_W'(evt_status) :
      hit_evt_mask ? DATA_W'(evt_mask_q) :
      hit_info     ? info_word           :
                     {DATA_W{1'b0}};

   // ************************************************************
   // apb handshake
   // ************************************************************
   assign setup_phase  = psel_i & ~penable_i;
   assign access_phase = psel_i & penable_i &
                         (apb_state_q == etr_pkg::ETR_APB_ACCESS);
   // writes land only at the completing edge; result bytes and the
   // block address have no write path at all
   assign wr_commit    = access_phase & pwrite_i;

   // one wait-free access: pready rises for the cycle after setup
   always_comb begin
      apb_state_d = apb_state_q;
      case (apb_state_q)
         etr_pkg::ETR_APB_IDLE: begin
            if (setup_phase) begin
               apb_state_d = etr_pkg::ETR_APB_ACCESS;
            end
         end
         etr_pkg::ETR_APB_ACCESS: begin
            apb_state_d = etr_pkg::ETR_APB_IDLE;
         end
         default: begin
            apb_state_d = etr_pkg::ETR_APB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         apb_state_q <= etr_pkg::ETR_APB_IDLE;
      end else begin
         apb_state_q <= apb_state_d;
      end
   end

   // answer registered at setup so the outputs come from flops
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= '0;
      end else if (apb_state_q == etr_pkg::ETR_APB_IDLE &&
                   setup_phase) begin
         pready_o  <= 1'b1;
         pslverr_o <= ~hit_any;
         prdata_o  <= pwrite_i ? {DATA_W{1'b0}} : rd_mux;
      end else begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= '0;
      end
   end

endmodule : etr_readout

`default_nettype wire

/* File: src/etr_cfg.svh */
/*
 * Offsets, field positions, reset values and widths of the ECC test
 * result readout block.
 * Assumes it is included by bare name from files under src/.
 */
`ifndef ETR_CFG_SVH
`define ETR_CFG_SVH

// ************************************************************
// register indices; byte address is four times the index
// ************************************************************
`define ETR_IDX_BYTE6      10'h2B6
`define ETR_IDX_BYTE7      10'h2B7
`define ETR_IDX_BYTE8      10'h2B8
`define ETR_IDX_CORRECTED_ERROR_BLOCK_ADDR    10'h2B9
`define ETR_IDX_EVT_STAT   10'h2C0
`define ETR_IDX_EVT_MASK   10'h2C1
`define ETR_IDX_INFO       10'h2C2

// ************************************************************
// widths and reset values
// ************************************************************
`define ETR_ADDR_W         12
`define ETR_DATA_W         32
`define ETR_BYTE_W         8
`define ETR_NUM_EVT        4
`define ETR_BYTE_RST       8'h00
`define ETR_EVT_RST        4'h0
`define ETR_MASK_RST       4'h0

// ************************************************************
// event status / mask bit positions
// ************************************************************
`define ETR_EVT_DEC_DONE   0
`define ETR_EVT_ENC_DONE   1
`define ETR_EVT_SEC_CAP    2
`define ETR_EVT_SEC_OVWR   3

// ************************************************************
// info register bit positions
// ************************************************************
`define ETR_INFO_MODE      0
`define ETR_INFO_SEC_FLAG  1
`define ETR_INFO_HELD      2

`endif

/* File: src/etr_pkg.sv */
/*
 * Types shared by the ECC test result readout block.
 * Assumes etr_cfg.svh supplies the numeric constants.
 */
`default_nettype none

package etr_pkg;

   // ************************************************************
   // self-test direction selected by software
   // ************************************************************
   typedef enum logic {
      ETR_MODE_DECODE = 1'b0,
      ETR_MODE_ENCODE = 1'b1
   } etr_mode_t;

   // ************************************************************
   // apb slave phase
   // ************************************************************
   typedef enum logic [1:0] {
      ETR_APB_IDLE   = 2'b00,
      ETR_APB_ACCESS = 2'b01
   } etr_apb_state_t;

endpackage : etr_pkg

`default_nettype wire

/* File: src/etr_byte_hold.sv */
/*
 * One read-only capture register: loads on a strobe, clears on a
 * second strobe, zero after reset.
 * Assumes load and clear come from logic on the same clock.
 */
`default_nettype none

module etr_byte_hold #(
   parameter int W = 8
) (
   input  wire logic         clock_i,
   input  wire logic         resetn_i,
   input  wire logic         load_i,
   input  wire logic         clear_i,
   input  wire logic [W-1:0] data_i,
   output logic      [W-1:0] q_o
);

   // load wins over clear so a fresh result is never dropped
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q_o <= '0;
      end else if (load_i) begin
         q_o <= data_i;
      end else if (clear_i) begin
         q_o <= '0;
      end
   end

endmodule : etr_byte_hold

`default_nettype wire

/* File: src/etr_sticky_bank.sv */
/*
 * Sticky event bits cleared by write-one, gated by a mask onto one
 * registered level interrupt.
 * Assumes set, clear and mask come from logic on the same clock.
 */
`default_nettype none

module etr_sticky_bank #(
   parameter int N = 4
) (
   input  wire logic         clock_i,
   input  wire logic         resetn_i,
   input  wire logic [N-1:0] set_i,
   input  wire logic [N-1:0] clr_i,
   input  wire logic [N-1:0] mask_i,
   output logic      [N-1:0] status_o,
   output logic              irq_o
);

   logic [N-1:0] status_d;

   // set beats clear in the same cycle: no event is lost
   assign status_d = (status_o & ~clr_i) | set_i;

   // irq follows the new status so it tracks status with no lag
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_o <= '0;
         irq_o    <= 1'b0;
      end else begin
         status_o <= status_d;
         irq_o    <= |(status_d & mask_i);
      end
   end

endmodule : etr_sticky_bank

`default_nettype wire

/* File: test/etr_readout_chk.sv */
/*
 * Checker for etr_readout: bus answer timing and read-back of the
 * held result bytes and corrected block address.
 * Assumes same-clock strobes and a master that keeps to APB.
 */
`include "etr_cfg.svh"
`default_nettype none

module etr_readout_chk #(
   parameter int ADDR_W = 12,
   parameter int DATA_W = 32
) (
   input wire logic              clock_i,
   input wire logic              resetn_i,
   input wire logic              psel_i,
   input wire logic              penable_i,
   input wire logic              pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [DATA_W-1:0] pwdata_i,
   input wire logic [DATA_W-1:0] prdata_o,
   input wire logic              pready_o,
   input wire logic              pslverr_o,
   input wire logic              test_result_valid_i,
   input wire logic              encode_decode_select_i,
   input wire logic [23:0]       test_result_upper_i,
   input wire logic              sec_event_i,
   input wire logic [7:0]        sec_block_i,
   input wire logic              single_error_detected_flag_i,
   input wire logic              irq_o
);
   // ********
   // reference copy of the held bytes
   // ********
   logic [7:0] b6_q;
   logic [7:0] b7_q;
   logic [7:0] b8_q;
   logic [7:0] blk_q;
   wire  [9:0] idx = paddr_i[11:2];
   // aligned words only; unaligned decode is left to the designer
   wire al = paddr_i[1:0] == 2'h0;
   wire mapped = idx == `ETR_IDX_BYTE6 || idx == `ETR_IDX_BYTE7
      || idx == `ETR_IDX_BYTE8 || idx == `ETR_IDX_CORRECTED_ERROR_BLOCK_ADDR
      || idx == `ETR_IDX_EVT_STAT || idx == `ETR_IDX_EVT_MASK
      || idx == `ETR_IDX_INFO;

   // bus writes never reach this copy, so a writable byte shows up
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         b6_q <= 8'h00;
         b7_q <= 8'h00;
         b8_q <= 8'h00;
         blk_q <= 8'h00;
      end else begin
         if (test_result_valid_i) begin
            b6_q <= test_result_upper_i[7:0];
            b7_q <= test_result_upper_i[15:8];
            b8_q <= encode_decode_select_i ? test_result_upper_i[23:16]
                                           : 8'h00;
         end
         if (sec_event_i) begin
            blk_q <= sec_block_i;
         end
      end
   end

   // ********
   // assertions
   // ********
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_read(logic [9:0] i);
      s_setup ##0 !pwrite_i && paddr_i == {i, 2'h0};
   endsequence

   a_ready_next: assert property (s_setup |=> pready_o)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_idle_zero: assert property (!pready_o |-> prdata_o == '0)
      else $error("read data outside ready");
   a_byte6_read: assert property (s_read(`ETR_IDX_BYTE6)
      |=> prdata_o == {24'h0, $past(b6_q)}) else $error("byte6 wrong");
   a_byte7_read: assert property (s_read(`ETR_IDX_BYTE7)
      |=> prdata_o == {24'h0, $past(b7_q)}) else $error("byte7 wrong");
   a_byte8_read: assert property (s_read(`ETR_IDX_BYTE8)
      |=> prdata_o == {24'h0, $past(b8_q)}) else $error("byte8 wrong");
   a_block_read: assert property (s_read(`ETR_IDX_CORRECTED_ERROR_BLOCK_ADDR)
      |=> prdata_o == {24'h0, $past(blk_q)}) else $error("block wrong");
   a_unmapped_err: assert property (s_setup ##0 al && !mapped
      |=> pslverr_o && prdata_o == '0) else $error("no error");
   // an unaligned byte address is not a register, so it is left out
   a_mapped_ok: assert property (s_setup ##0 al && mapped
      |=> !pslverr_o) else $error("error on mapped address");
endmodule : etr_readout_chk

bind etr_readout etr_readout_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
   .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .test_result_valid_i(test_result_valid_i),
   .encode_decode_select_i(encode_decode_select_i),
   .test_result_upper_i(test_result_upper_i), .sec_event_i(sec_event_i),
   .sec_block_i(sec_block_i),
   .single_error_detected_flag_i(single_error_detected_flag_i),
   .irq_o(irq_o));

`default_nettype wire

/* File: test/tb_etr_readout.sv */
/*
 * Testbench for etr_readout: APB master, self-test and corrector
 * strobes, interrupt checks.
 * Assumes the src/ files and the checker are compiled first.
 */
`include "etr_cfg.svh"
`default_nettype none

module tb_etr_readout;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] A6 = {`ETR_IDX_BYTE6, 2'h0};
   localparam logic [11:0] A7 = {`ETR_IDX_BYTE7, 2'h0};
   localparam logic [11:0] A8 = {`ETR_IDX_BYTE8, 2'h0};
   localparam logic [11:0] AB = {`ETR_IDX_CORRECTED_ERROR_BLOCK_ADDR, 2'h0};
   localparam logic [11:0] AS = {`ETR_IDX_EVT_STAT, 2'h0};
   localparam logic [11:0] AM = {`ETR_IDX_EVT_MASK, 2'h0};
   localparam logic [11:0] AI = {`ETR_IDX_INFO, 2'h0};
   localparam logic [11:0] ALL[7] = '{A6, A7, A8, AB, AS, AM, AI};
   logic        clock_i = 1'h0;
   logic        resetn_i = 1'h0;
   logic        psel_i = 1'h0;
   logic        penable_i = 1'h0;
   logic        pwrite_i = 1'h0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic        valid_i = 1'h0;
   logic        sel_i = 1'h0;
   logic [23:0] upper_i = 24'h0;
   logic        sec_i = 1'h0;
   logic [7:0]  blk_i = 8'h00;
   logic        flag_i = 1'h0;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        irq_o;
   int          n_errors = 0;
   int          comparisons = 0;

   always #25 clock_i = ~clock_i;

   etr_readout dut (.clock_i(clock_i), .resetn_i(resetn_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o),
      .test_result_valid_i(valid_i), .encode_decode_select_i(sel_i),
      .test_result_upper_i(upper_i), .sec_event_i(sec_i),
      .sec_block_i(blk_i), .single_error_detected_flag_i(flag_i),
      .irq_o(irq_o));

   // ********
   // shared tasks
   // ********
   task automatic final_report();
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report

   task automatic check(input string nm, input logic [31:0] got,
                        input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   // ready, read data and error are taken at the completing rising
   // edge; the request is released only then
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [31:0] exp,
                      input logic err);
      int n;
      n = 0;
      @(posedge clock_i);
      psel_i <= 1'h1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'h1;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready_o !== 1'h1 && n < 16);
      if (pready_o !== 1'h1) begin
         n_errors++;
         final_report();
      end
      if (!w) check($sformatf("reg %h", a), prdata_o, exp);
      check($sformatf("err %h", a), {31'h0, pslverr_o}, {31'h0, err});
      psel_i <= 1'h0;
      penable_i <= 1'h0;
   endtask : apb

   task automatic result(input logic s, input logic [23:0] u);
      @(posedge clock_i);
      valid_i <= 1'h1;
      sel_i <= s;
      upper_i <= u;
      @(posedge clock_i);
      valid_i <= 1'h0;
   endtask : result

   task automatic correct(input logic [7:0] b);
      @(posedge clock_i);
      sec_i <= 1'h1;
      blk_i <= b;
      @(posedge clock_i);
      sec_i <= 1'h0;
   endtask : correct

   // ********
   // scenarios
   // ********
   task automatic t_reset();
      foreach (ALL[i]) apb(0, ALL[i], 0, 32'h0, 0);
      $display("done reset values");
   endtask : t_reset

   task automatic t_results();
      result(1, 24'hC35AA5);
      apb(0, A6, 0, 32'hA5, 0);
      apb(0, A8, 0, 32'hC3, 0);
      apb(0, AI, 0, 32'h5, 0);
      result(0, 24'h96E187);
      apb(0, A7, 0, 32'hE1, 0);
      apb(0, A8, 0, 32'h00, 0);
      apb(0, AS, 0, 32'h3, 0);
      $display("done results");
   endtask : t_results

   // two corrections with one idle cycle between: the later block must win
   task automatic t_sec();
      flag_i <= 1'h1;
      repeat (2) @(posedge clock_i);
      correct(8'h81);
      correct(8'h7E);
      apb(0, AB, 0, 32'h7E, 0);
      apb(0, AS, 0, 32'hF, 0);
      apb(0, AI, 0, 32'h6, 0);
      flag_i <= 1'h0;
      $display("done correction");
   endtask : t_sec

   task automatic t_readonly();
      apb(1, A6, 32'hFF, 0, 0);
      apb(1, AB, 32'hFF, 0, 0);
      apb(0, A6, 0, 32'h87, 0);
      apb(0, AB, 0, 32'h7E, 0);
      apb(1, 12'hAEC, 32'hFF, 0, 1);
      apb(0, 12'hAEC, 0, 32'h0, 1);
      $display("done read only");
   endtask : t_readonly

   task automatic t_irq();
      apb(1, AS, 32'hF, 0, 0);
      apb(0, AS, 0, 32'h0, 0);
      correct(8'h42);
      repeat (2) @(negedge clock_i);
      check("irq masked", {31'h0, irq_o}, 32'h0);
      apb(0, AS, 0, 32'h4, 0);
      apb(1, AM, 32'h4, 0, 0);
      repeat (2) @(negedge clock_i);
      check("irq raised", {31'h0, irq_o}, 32'h1);
      apb(1, AS, 32'h4, 0, 0);
      repeat (2) @(negedge clock_i);
      check("irq cleared", {31'h0, irq_o}, 32'h0);
      apb(0, AB, 0, 32'h42, 0);
      $display("done interrupt");
   endtask : t_irq

   initial begin
      repeat (12) @(posedge clock_i);
      resetn_i <= 1'h1;
      t_reset();
      t_results();
      t_sec();
      t_readonly();
      t_irq();
      final_report();
   end
endmodule : tb_etr_readout

`default_nettype wire
